/* File: shared/mns_defines.svh */
`ifndef MNS_DEFINES_SVH
`define MNS_DEFINES_SVH

// opcode decode masks and patterns
`define MNS_MASK_LIT        16'hFF00
`define MNS_PAT_MUL_LIT     16'h0D00
`define MNS_MASK_FILE       16'hFE00
`define MNS_PAT_MUL_FILE    16'h0200
`define MNS_PAT_NEGATE      16'h6C00
`define MNS_PAT_STORE       16'h6E00
`define MNS_ACCESS_BIT      8

// file operand addressing
`define MNS_INDEXED_LIMIT   8'h5F
`define MNS_ACCESS_SPLIT    8'h60
`define MNS_ACCESS_HI_BANK  4'hF
`define MNS_ACCESS_LO_BANK  4'h0

// flag vector bit positions
`define MNS_FLAG_C          0
`define MNS_FLAG_DC         1
`define MNS_FLAG_Z          2
`define MNS_FLAG_OV         3
`define MNS_FLAG_N          4

// reset values
`define MNS_PROD_RESET      8'h00
`define MNS_ADDR_RESET      12'h000
`define MNS_FLAGS_RESET     5'h00

`endif

/* File: shared/mns_pkg.sv */
package mns_pkg;

	typedef enum logic [2:0] {
		MNS_OP_NONE,
		MNS_OP_STORE,
		MNS_OP_MUL_LIT,
		MNS_OP_MUL_FILE,
		MNS_OP_NEGATE
	} mns_op_type;

	typedef enum logic [2:0] {
		MNS_ST_IDLE,
		MNS_ST_Q1,
		MNS_ST_Q2,
		MNS_ST_Q3,
		MNS_ST_Q4
	} mns_state_type;

endpackage

/* File: hdl/mns_addr_gen.sv */
`timescale 1ns/1ns
`include "mns_defines.svh"

// combinational file operand address former
module mns_addr_gen #(
	parameter int BANK_W = 4
) (
	input  wire logic [7:0]        i_file_offset,
	input  wire logic              i_access_sel,
	input  wire logic              i_ext_en,
	input  wire logic [BANK_W-1:0] i_bank_select_pointer,
	input  wire logic [11:0]       i_index_base,
	output logic      [11:0]       o_addr,
	output logic                   o_indexed
);

	always_comb begin
		o_indexed = 1'b0;
		if (i_access_sel) begin
			o_addr = {i_bank_select_pointer, i_file_offset};
		end else if (i_ext_en && (i_file_offset <= `MNS_INDEXED_LIMIT)) begin
			o_indexed = 1'b1;
			o_addr    = i_index_base + {4'h0, i_file_offset};
		end else if (i_file_offset < `MNS_ACCESS_SPLIT) begin
			o_addr = {`MNS_ACCESS_LO_BANK, i_file_offset};
		end else begin
			// access bank upper part maps onto special registers
			o_addr = {`MNS_ACCESS_HI_BANK, i_file_offset};
		end
	end

endmodule // mns_addr_gen

/* File: hdl/mns_exec.sv */
`timescale 1ns/1ns
`include "mns_defines.svh"

// Summary of operation
// - extended set, a=0, f<=5Fh uses indexed mode
// - literal multiply, 16-bit product, accumulator kept
// - file multiply into product pair, sources kept
// - multiplies never touch status flags
// - negate file register, update N OV C DC Z
// - a=0 access bank, a=1 bank pointer
module mns_exec #(
	parameter int BANK_W = 4
) (
	input  wire logic              i_mclk,
	input  wire logic              i_resetn,
	input  wire logic              i_start,
	input  wire logic [15:0]       i_opcode,
	input  wire logic [7:0]        i_accumulator,
	input  wire logic [BANK_W-1:0] i_bank_select_pointer,
	input  wire logic              i_ext_en,
	input  wire logic [11:0]       i_index_base,
	input  wire logic [7:0]        i_mem_rdata,
	output logic      [11:0]       o_mem_addr,
	output logic                   o_mem_rd,
	output logic                   o_mem_wr,
	output logic      [7:0]        o_mem_wdata,
	output logic      [7:0]        o_product_high_byte,
	output logic      [7:0]        o_product_low_byte,
	output logic                   o_flags_we,
	output logic      [4:0]        o_flags,
	output logic                   o_indexed,
	output logic                   o_busy,
	output logic                   o_done,
	output logic                   o_unknown_op
);

	////////////////////////////////////////////////////////////////////////////
	// decode

	function automatic mns_pkg::mns_op_type decode_op(input logic [15:0] op);
		if ((op & `MNS_MASK_LIT) == `MNS_PAT_MUL_LIT)
			return mns_pkg::MNS_OP_MUL_LIT;
		else if ((op & `MNS_MASK_FILE) == `MNS_PAT_MUL_FILE)
			return mns_pkg::MNS_OP_MUL_FILE;
		else if ((op & `MNS_MASK_FILE) == `MNS_PAT_NEGATE)
			return mns_pkg::MNS_OP_NEGATE;
		else if ((op & `MNS_MASK_FILE) == `MNS_PAT_STORE)
			return mns_pkg::MNS_OP_STORE;
		else
			return mns_pkg::MNS_OP_NONE;
	endfunction

	// carry out of the low n bits of (~x + 1) is set only when those bits are zero
	function automatic logic neg_carry(input logic [7:0] x, input int unsigned n);
		logic c;
		c = 1'b1;
		for (int i = 0; i < 8; i++) begin
			if (i < n && x[i])
				c = 1'b0;
		end
		return c;
	endfunction

	mns_pkg::mns_state_type state_q;
	mns_pkg::mns_state_type state_d;
	mns_pkg::mns_op_type    op_q;
	mns_pkg::mns_op_type    op_d;
	logic [7:0]             lit_q;
	logic [7:0]             lit_d;
	logic [7:0]             acc_q;
	logic [7:0]             acc_d;
	logic [7:0]             opnd_q;
	logic [7:0]             opnd_d;
	logic [11:0]            addr_q;
	logic [11:0]            addr_d;
	logic                   access_q;
	logic                   access_d;
	logic                   rd_q;
	logic                   rd_d;
	logic                   wr_q;
	logic                   wr_d;
	logic [7:0]             wdata_q;
	logic [7:0]             wdata_d;
	logic [7:0]             prod_hi_q;
	logic [7:0]             prod_hi_d;
	logic [7:0]             prod_lo_q;
	logic [7:0]             prod_lo_d;
	logic                   flags_we_q;
	logic                   flags_we_d;
	logic [4:0]             flags_q;
	logic [4:0]             flags_d;
	logic                   idx_q;
	logic                   idx_d;
	logic                   busy_q;
	logic                   busy_d;
	logic                   done_q;
	logic                   done_d;
	logic                   unk_q;
	logic                   unk_d;
	logic [11:0]            gen_addr;
	logic                   gen_idx;
	logic [15:0]            product;
	logic [7:0]             neg_val;

	mns_addr_gen #(
		.BANK_W(BANK_W)
	) u_addr (
		.i_file_offset         (lit_q),
		.i_access_sel          (access_q),
		.i_ext_en              (i_ext_en),
		.i_bank_select_pointer (i_bank_select_pointer),
		.i_index_base          (i_index_base),
		.o_addr                (gen_addr),
		.o_indexed             (gen_idx)
	);

	// each multiply has its own unsigned multiplier, op_q picks which product is used
	assign product = (op_q == mns_pkg::MNS_OP_MUL_LIT) ? (acc_q * lit_q) : (acc_q * opnd_q);
	assign neg_val = 8'(~opnd_q + 8'h01);

	////////////////////////////////////////////////////////////////////////////
	// quarter sequencer and datapath

	always_comb begin
		state_d    = state_q;
		op_d       = op_q;
		lit_d      = lit_q;
		acc_d      = acc_q;
		opnd_d     = opnd_q;
		addr_d     = addr_q;
		access_d   = access_q;
		rd_d       = 1'b0;
		wr_d       = 1'b0;
		wdata_d    = wdata_q;
		prod_hi_d  = prod_hi_q;
		prod_lo_d  = prod_lo_q;
		flags_we_d = 1'b0;
		flags_d    = flags_q;
		idx_d      = idx_q;
		busy_d     = busy_q;
		done_d     = 1'b0;
		unk_d      = 1'b0;
		case (state_q)
			mns_pkg::MNS_ST_IDLE: begin
				if (i_start) begin
					op_d     = decode_op(i_opcode);
					lit_d    = i_opcode[7:0];
					access_d = i_opcode[`MNS_ACCESS_BIT];
					acc_d    = i_accumulator;
					busy_d   = 1'b1;
					state_d  = mns_pkg::MNS_ST_Q1;
				end
			end
			mns_pkg::MNS_ST_Q1: begin
				if (op_q == mns_pkg::MNS_OP_NONE) begin
					// unknown words finish at once so the decoder is never stuck
					unk_d   = 1'b1;
					done_d  = 1'b1;
					busy_d  = 1'b0;
					state_d = mns_pkg::MNS_ST_IDLE;
				end else begin
					if (op_q != mns_pkg::MNS_OP_MUL_LIT) begin
						addr_d = gen_addr;
						idx_d  = gen_idx;
					end else begin
						idx_d  = 1'b0;
					end
					rd_d    = (op_q == mns_pkg::MNS_OP_MUL_FILE) || (op_q == mns_pkg::MNS_OP_NEGATE);
					state_d = mns_pkg::MNS_ST_Q2;
				end
			end
			mns_pkg::MNS_ST_Q2: begin
				if (rd_q)
					opnd_d = i_mem_rdata;
				state_d = mns_pkg::MNS_ST_Q3;
			end
			// process quarter, results land with Q4
			mns_pkg::MNS_ST_Q3: begin
				case (op_q)
					mns_pkg::MNS_OP_MUL_LIT,
					mns_pkg::MNS_OP_MUL_FILE: begin
						prod_hi_d = product[15:8];
						prod_lo_d = product[7:0];
					end
					mns_pkg::MNS_OP_NEGATE: begin
						wr_d       = 1'b1;
						wdata_d    = neg_val;
						flags_we_d = 1'b1;
						flags_d[`MNS_FLAG_N]  = neg_val[7];
						flags_d[`MNS_FLAG_Z]  = (neg_val == 8'h00);
						flags_d[`MNS_FLAG_OV] = (opnd_q == 8'h80);
						flags_d[`MNS_FLAG_C]  = neg_carry(opnd_q, 8);
						flags_d[`MNS_FLAG_DC] = neg_carry(opnd_q, 4);
					end
					mns_pkg::MNS_OP_STORE: begin
						wr_d    = 1'b1;
						wdata_d = acc_q;
					end
					default: begin
						wr_d = 1'b0;
					end
				endcase
				done_d  = 1'b1;
				state_d = mns_pkg::MNS_ST_Q4;
			end
			mns_pkg::MNS_ST_Q4: begin
				busy_d  = 1'b0;
				state_d = mns_pkg::MNS_ST_IDLE;
			end
			default: begin
				busy_d  = 1'b0;
				state_d = mns_pkg::MNS_ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			state_q    <= mns_pkg::MNS_ST_IDLE;
			op_q       <= mns_pkg::MNS_OP_NONE;
			lit_q      <= 8'h00;
			acc_q      <= 8'h00;
			opnd_q     <= 8'h00;
			addr_q     <= `MNS_ADDR_RESET;
			access_q   <= 1'b0;
			rd_q       <= 1'b0;
			wr_q       <= 1'b0;
			wdata_q    <= 8'h00;
			prod_hi_q  <= `MNS_PROD_RESET;
			prod_lo_q  <= `MNS_PROD_RESET;
			flags_we_q <= 1'b0;
			flags_q    <= `MNS_FLAGS_RESET;
			idx_q      <= 1'b0;
			busy_q     <= 1'b0;
			done_q     <= 1'b0;
			unk_q      <= 1'b0;
		end else begin
			state_q    <= state_d;
			op_q       <= op_d;
			lit_q      <= lit_d;
			acc_q      <= acc_d;
			opnd_q     <= opnd_d;
			addr_q     <= addr_d;
			access_q   <= access_d;
			rd_q       <= rd_d;
			wr_q       <= wr_d;
			wdata_q    <= wdata_d;
			prod_hi_q  <= prod_hi_d;
			prod_lo_q  <= prod_lo_d;
			flags_we_q <= flags_we_d;
			flags_q    <= flags_d;
			idx_q      <= idx_d;
			busy_q     <= busy_d;
			done_q     <= done_d;
			unk_q      <= unk_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs

	assign o_mem_addr          = addr_q;
	assign o_mem_rd            = rd_q;
	assign o_mem_wr            = wr_q;
	assign o_mem_wdata         = wdata_q;
	assign o_product_high_byte = prod_hi_q;
	assign o_product_low_byte  = prod_lo_q;
	assign o_flags_we          = flags_we_q;
	assign o_flags             = flags_q;
	assign o_indexed           = idx_q;
	assign o_busy              = busy_q;
	assign o_done              = done_q;
	assign o_unknown_op        = unk_q;

endmodule // mns_exec

/* File: tb/mns_mem_model.sv */
`timescale 1ns/1ns
module mns_mem_model (
	input  wire logic        i_mclk,
	input  wire logic [11:0] i_addr,
	input  wire logic        i_rd,
	input  wire logic        i_wr,
	input  wire logic [7:0]  i_wdata,
	output logic      [7:0]  o_rdata
);
	logic [7:0] mem [4096];
	logic [7:0] last_q = 8'h00;
	initial for (int i = 0; i < 4096; i++) mem[i] = i[7:0] ^ 8'h5A;
	// idle bus shows the inverse, so a late sample never matches
	assign o_rdata = i_rd ? mem[i_addr] : ~last_q;
	always @(posedge i_mclk) begin
		if (i_rd) last_q <= mem[i_addr];
		if (i_wr) mem[i_addr] <= i_wdata;
	end
endmodule // mns_mem_model

/* File: tb/mns_exec_chk.sv */
`timescale 1ns/1ns
`include "mns_defines.svh"
module mns_exec_chk #(
	parameter int BANK_W = 4
) (
	input wire logic              i_mclk,
	input wire logic              i_resetn,
	input wire logic              i_start,
	input wire logic [15:0]       i_opcode,
	input wire logic [7:0]        i_accumulator,
	input wire logic [BANK_W-1:0] i_bank_select_pointer,
	input wire logic              i_ext_en,
	input wire logic [11:0]       i_index_base,
	input wire logic [7:0]        i_mem_rdata,
	input wire logic [11:0]       o_mem_addr,
	input wire logic              o_mem_rd,
	input wire logic              o_mem_wr,
	input wire logic [7:0]        o_mem_wdata,
	input wire logic [7:0]        o_product_high_byte,
	input wire logic [7:0]        o_product_low_byte,
	input wire logic              o_flags_we,
	input wire logic [4:0]        o_flags,
	input wire logic              o_indexed,
	input wire logic              o_busy,
	input wire logic              o_done
);
	logic [15:0] op_d, op_q;
	logic [7:0]  acc_d, acc_q;
	logic        tk_d, tk_q;
	always_comb begin
		tk_d = i_start && !o_busy;
		op_d = tk_d ? i_opcode : op_q;
		acc_d = tk_d ? i_accumulator : acc_q;
	end
	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			tk_q <= 1'b0;
			op_q <= 16'h0000;
			acc_q <= 8'h00;
		end else begin
			tk_q <= tk_d;
			op_q <= op_d;
			acc_q <= acc_d;
		end
	end
	wire lt = (op_q & `MNS_MASK_LIT) == `MNS_PAT_MUL_LIT;
	wire fm = (op_q & `MNS_MASK_FILE) == `MNS_PAT_MUL_FILE;
	wire ng = (op_q & `MNS_MASK_FILE) == `MNS_PAT_NEGATE;
	wire st = (op_q & `MNS_MASK_FILE) == `MNS_PAT_STORE;
	wire fo = fm || ng || st;
	wire [7:0] f = op_q[7:0];
	wire ix = !op_q[`MNS_ACCESS_BIT] && i_ext_en && f <= `MNS_INDEXED_LIMIT;
	wire [15:0] prod = {o_product_high_byte, o_product_low_byte};
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_resetn);
	sequence s_q4_done;
		!o_done [*3] ##1 o_done ##1 !o_busy;
	endsequence
	sequence s_read;
		o_mem_rd ##1 !o_mem_rd;
	endsequence
	a_cycle_done: assert property (tk_q && (fo || lt) |-> s_q4_done)
		else $error("done not in fourth quarter");
	a_read_slot: assert property (tk_q && (fm || ng) |=> s_read)
		else $error("file read not in second quarter");
	a_no_read: assert property (tk_q && (lt || st) |-> !o_mem_rd [*4])
		else $error("unexpected memory read");
	a_mul_quiet: assert property (tk_q && (lt || fm) |-> !(o_flags_we || o_mem_wr) [*4])
		else $error("multiply touched flags or memory");
	a_lit_prod: assert property (tk_q && lt |-> ##3 prod == acc_q * f)
		else $error("literal product wrong");
	// read data stands only in the quarter with o_mem_rd high, two samples back
	a_file_prod: assert property (tk_q && fm |-> ##3 prod == acc_q * $past(i_mem_rdata, 2))
		else $error("file product wrong");
	a_neg_write: assert property (tk_q && ng |-> ##3 o_mem_wr && o_flags_we
		&& o_mem_wdata == 8'h00 - $past(i_mem_rdata, 2) && o_flags[4] == o_mem_wdata[7]
		&& o_flags[2] == (o_mem_wdata == 8'h00))
		else $error("negate result wrong");
	a_index_mode: assert property (tk_q && fo && ix |=> o_indexed
		&& o_mem_addr == $past(i_index_base) + f)
		else $error("indexed address wrong");
	a_bank_mode: assert property (tk_q && fo && op_q[8] |=> !o_indexed
		&& o_mem_addr == {$past(i_bank_select_pointer), f})
		else $error("banked address wrong");
	a_access_bank: assert property (tk_q && fo && !op_q[8] && !ix |=> !o_indexed
		&& o_mem_addr == {(f < `MNS_ACCESS_SPLIT) ? 4'h0 : 4'hF, f})
		else $error("access bank address wrong");
endmodule // mns_exec_chk
bind mns_exec mns_exec_chk #(.BANK_W(BANK_W)) u_chk (.*);

/* File: tb/mns_exec_tb_top.sv */
`timescale 1ns/1ns
module mns_exec_tb_top;
	logic        i_mclk = 0, i_resetn = 0, i_start = 0, i_ext_en = 0;
	logic [15:0] i_opcode = 0;
	logic [7:0]  i_accumulator = 0;
	logic [3:0]  bsp = 0;
	logic [11:0] i_index_base = 0;
	wire  [11:0] o_mem_addr;
	wire  [7:0]  rdata, wdata, ph, pl;
	wire  [4:0]  o_flags;
	wire         rd, wr, fwe, o_indexed, o_busy, o_done, o_unknown_op;
	int          err_total = 0, n_tests = 0, k;
	logic [15:0] p_exp = 0;
	logic [15:0] bases [5] = '{16'h0D00, 16'h0200, 16'h6C00, 16'h6E00, 16'hF000};
	// ext, accumulator, opcode
	logic [24:0] cor [14] = '{25'h0_E2_0DC4, 25'h0_B5_6F10, 25'h0_C4_0310, 25'h0_00_6F10,
		25'h0_00_6D10, 25'h0_80_6F10, 25'h0_00_6D10, 25'h1_3A_6E5F, 25'h1_00_6C5F,
		25'h1_11_6E60, 25'h0_22_6E20, 25'h1_C4_0260, 25'h0_00_F000, 25'h0_FF_0DFF};
	mns_exec #(.BANK_W(4)) dut (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_start(i_start),
		.i_opcode(i_opcode), .i_accumulator(i_accumulator), .i_bank_select_pointer(bsp),
		.i_ext_en(i_ext_en), .i_index_base(i_index_base), .i_mem_rdata(rdata),
		.o_mem_addr(o_mem_addr), .o_mem_rd(rd), .o_mem_wr(wr), .o_mem_wdata(wdata),
		.o_product_high_byte(ph), .o_product_low_byte(pl), .o_flags_we(fwe),
		.o_flags(o_flags), .o_indexed(o_indexed), .o_busy(o_busy), .o_done(o_done),
		.o_unknown_op(o_unknown_op));
	mns_mem_model u_mem (.i_mclk(i_mclk), .i_addr(o_mem_addr), .i_rd(rd), .i_wr(wr),
		.i_wdata(wdata), .o_rdata(rdata));
	initial forever #50 i_mclk = ~i_mclk;
	////////////////////////////////////////////////////////////////
	function logic [11:0] ea(input logic [15:0] w, input logic e, input logic [3:0] b,
		input logic [11:0] x);
		if (w[8]) return {b, w[7:0]};
		if (e && w[7:0] <= 8'h5F) return x + w[7:0];
		return {(w[7:0] < 8'h60) ? 4'h0 : 4'hF, w[7:0]};
	endfunction
	function logic [4:0] nf(input logic [7:0] x);
		logic [7:0] r;
		r = 8'h00 - x;
		return {r[7], x == 8'h80, r == 8'h00, x[3:0] == 4'h0, x == 8'h00};
	endfunction
	task chk(input string nm, input logic [15:0] e, input logic [15:0] s);
		n_tests++;
		if (e !== s) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", nm, e, s);
		end
	endtask
	task wrap_up;
		$display("tests %0d errors %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	// start stays high until done rises, so every op also probes the ignore
	task op(input logic [15:0] w, input logic [7:0] a, input logic e, input logic rnd);
		logic [3:0] b;
		logic [11:0] x, ad;
		logic [7:0] m;
		logic lt, fm, ng, st, ix;
		int n;
		b = rnd ? 4'($urandom) : 4'h3;
		x = rnd ? 12'($urandom) : 12'h7F0;
		ad = ea(w, e, b, x);
		ix = !w[8] && e && (w[7:0] <= 8'h5F);
		lt = w[15:8] == 8'h0D;
		fm = w[15:9] == 7'h01;
		ng = w[15:9] == 7'h36;
		st = w[15:9] == 7'h37;
		n = (lt || fm || ng || st) ? 4 : 2;
		@(posedge i_mclk);
		i_start <= 1'b1;
		i_opcode <= w;
		i_accumulator <= a;
		i_ext_en <= e;
		bsp <= b;
		i_index_base <= x;
		// done stands one cycle only, so stop at the edge that raises it
		for (int i = 0; i < n; i++) begin
			@(posedge i_mclk);
			if (i == n - 1) i_start <= 1'b0;
			#1;
			// operand taken after the previous write has landed
			if (i == 0) m = u_mem.mem[ad];
			if (i == 2 && n == 4 && !lt) chk("addr", {3'h0, ix, ad}, {3'h0, o_indexed, o_mem_addr});
		end
		if (lt) p_exp = a * w[7:0];
		if (fm) p_exp = a * m;
		chk("done", {n == 4, 1'b1}, {!o_unknown_op, o_done});
		chk("prod", p_exp, {ph, pl});
		chk("wr", {ng, ng | st}, {fwe, wr});
		if (ng) chk("neg", {nf(m), 8'h00 - m}, {o_flags, wdata});
		if (st) chk("st", a, wdata);
	endtask
	initial begin
		void'($urandom(37));
		repeat (5) @(posedge i_mclk);
		i_resetn <= 1'b1;
		foreach (cor[i]) op(cor[i][15:0], cor[i][23:16], cor[i][24], 1'b0);
		repeat (60) begin
			k = $urandom % 5;
			op(bases[k] | (16'($urandom) & 16'h01FF), 8'($urandom), 1'($urandom), 1'b1);
		end
		wrap_up;
	end
	// generous: the run needs well under 1000 cycles
	initial begin
		#300000;
		err_total++;
		wrap_up;
	end
endmodule // mns_exec_tb_top
